// >>> include/servo_setup_consts.svh
// register offsets, field positions, reset values and timing counts for the setup decoder
`ifndef SERVO_SETUP_CONSTS_SVH
`define SERVO_SETUP_CONSTS_SVH

`define ADDR_W              8
`define OFF_FIRST_SETUP     8'h00
`define OFF_SECOND_SETUP    8'h04
`define OFF_PULSE_COUNT     8'h08
`define OFF_ACTIVE_FIRST    8'h0c
`define OFF_ACTIVE_SECOND   8'h10
`define OFF_MODE_STATUS     8'h14
`define OFF_IRQ_STATUS      8'h18
`define OFF_IRQ_CLEAR       8'h1c
`define OFF_IRQ_ENABLE      8'h20

`define FIRST_SETUP_RESET   16'h0000
`define SECOND_SETUP_RESET  16'h0000
`define PULSE_COUNT_RESET   16'h0000
`define ABS_PULSE_COUNT     16'h0400

// second setup word fields
`define B2_POLARITY         0
`define B2_ORIGIN_MASK      1
`define B2_CMD_SOURCE       2
`define B2_INTEG_UNITS      11
`define B2_FILTER_ORDER     12
`define B2_ANALOG_LIMIT     15
`define B2_MUST_ZERO        16'h61fa

// first setup word fields
`define B1_STOP_LO          6
`define B1_STOP_HI          9
`define B1_MODE_LO          10
`define B1_MODE_HI          11
`define B1_ENCODER          14

// integrator step in microseconds
`define INTEG_STEP_COARSE   10'h3e8
`define INTEG_STEP_FINE     10'h00a

`define CURRENT_LIMIT_FULL  12'hfff

`define IRQ_APPLIED         0
`define IRQ_PENDING         1
`define IRQ_RESERVED        2
`define IRQ_PULSE_COUNT     3
`define IRQ_W               4

`endif

// >>> include/servo_setup_pkg.sv
// types shared by the setup decoder
package servo_setup_pkg;

  typedef enum logic [2:0] {
    mode_speed,
    mode_speed_position_lock,
    mode_torque,
    mode_torque_speed_switch,
    mode_preset_servo_lock,
    mode_preset_position_lock,
    mode_preset_speed_servo_lock,
    mode_preset_speed_position_lock
  } control_mode_e;

endpackage : servo_setup_pkg

// >>> rtl/servo_setup_mode_decoder.sv
// decoder of the two setup words into the drive's active control settings
//
// What this block does
// R1 - polarity bit 0: positive command turns CCW; 1: turns CW
// R2 - origin mask 0 detects absolute encoder origin errors; 1 suppresses them
// R3 - command source 0: current limit inputs; 1: speed selects plus direction
// R4 - integrator units bit picks 1 ms or 0.01 ms steps
// R5 - filter order bit picks first or second order torque filter
// R6 - analog limit bit sets current limit from torque input, speed control only
// R7 - host keeps origin mask, bits 3 to 8, d and E at defaults
// R8 - written setup values take effect only after a power reset
// R9 - command source 0: mode selector picks four analog modes
// R10 - command source 1: low bit picks stop lock, high bit adds analog speed
// R11 - reduced variant with command source 1 forces presets only, servo lock
// R12 - encoder bit 0 incremental (default), 1 absolute
// R13 - host programs pulse count 1024 when absolute encoder selected
// R14 - first word bits six to nine select the stopping method
// R15 - second setup word resets to zero
`timescale 1ns/1ns
`include "servo_setup_consts.svh"
module servo_setup_mode_decoder
  import servo_setup_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  // register port
  input  wire logic [`ADDR_W-1:0]   reg_addr,
  input  wire logic [31:0]          reg_wdata,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  output logic      [31:0]          reg_rdata,
  output logic                      irq,
  // pins
  input  wire logic                 power_restart,
  input  wire logic                 reduced_variant,
  input  wire logic                 multipurpose_in_one,
  input  wire logic                 multipurpose_in_two,
  input  wire logic                 multipurpose_in_three,
  // same-clock datapath
  input  wire logic signed [15:0]   speed_command,
  input  wire logic [11:0]          torque_command_in,
  // decoded settings
  output logic signed [15:0]        motor_speed_command,
  output logic                      rotate_cw_positive,
  output logic                      origin_error_detect_en,
  output logic                      forward_current_limit_in,
  output logic                      reverse_current_limit_in,
  output logic                      speed_select_one,
  output logic                      speed_select_two,
  output logic                      rotation_direction_in,
  output logic [9:0]                integ_step_us,
  output logic                      torque_filter_second_order,
  output logic                      analog_current_limit_en,
  output logic [11:0]               current_limit_level,
  output control_mode_e             control_mode,
  output logic                      absolute_encoder_option,
  output logic [3:0]                stop_method
);

  // ---------------- pin synchronisation ----------------
  logic [4:0] pins_sync;

  sync_two_stage #(
    .W (5)
  ) u_pin_sync (
    .clk      (clk),
    .rst_n    (rst_n),
    .async_in ({reduced_variant, power_restart, multipurpose_in_three,
                multipurpose_in_two, multipurpose_in_one}),
    .sync_out (pins_sync)
  );

  wire mp_one     = pins_sync[0];
  wire mp_two     = pins_sync[1];
  wire mp_three   = pins_sync[2];
  wire restart_lv = pins_sync[3];
  wire strap_lv   = pins_sync[4];

  logic       restart_prev;
  logic       strap_taken;
  logic       reduced_strap;
  logic [1:0] strap_age;

  // resets to the idle low level so no false restart edge follows reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      restart_prev <= 1'b0;
    end else begin
      restart_prev <= restart_lv;
    end
  end

  // strap taken once the synchroniser has refilled after reset,
  // so its reset zero is never mistaken for the strap level
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      strap_age     <= 2'h0;
      strap_taken   <= 1'b0;
      reduced_strap <= 1'b0;
    end else if (!strap_taken) begin
      if (strap_age == 2'h2) begin
        strap_taken   <= 1'b1;
        reduced_strap <= strap_lv;
      end else begin
        strap_age <= strap_age + 2'h1;
      end
    end
  end

  // a power restart is the only moment staged settings become active
  wire apply_now = restart_lv & ~restart_prev;

  // ---------------- register decode ----------------
  logic [15:0] first_setup_word;
  logic [15:0] second_setup_word;
  logic [15:0] encoder_pulse_count_param;
  logic [15:0] active_first;
  logic [15:0] active_second;
  logic [`IRQ_W-1:0] irq_status;
  logic [`IRQ_W-1:0] irq_enable;

  wire hit_first   = reg_addr == `OFF_FIRST_SETUP;
  wire hit_second  = reg_addr == `OFF_SECOND_SETUP;
  wire hit_pulse   = reg_addr == `OFF_PULSE_COUNT;
  wire hit_clear   = reg_addr == `OFF_IRQ_CLEAR;
  wire hit_enable  = reg_addr == `OFF_IRQ_ENABLE;

  wire wr_first    = reg_wr & hit_first;
  wire wr_second   = reg_wr & hit_second;
  wire wr_pulse    = reg_wr & hit_pulse;
  wire wr_clear    = reg_wr & hit_clear;
  wire wr_enable   = reg_wr & hit_enable;

  wire [15:0] wdata16 = reg_wdata[15:0];

  // staged words reset to factory values; live behaviour ignores them
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      first_setup_word          <= `FIRST_SETUP_RESET;
      second_setup_word         <= `SECOND_SETUP_RESET; // see R15
      encoder_pulse_count_param <= `PULSE_COUNT_RESET;
    end else begin
      if (wr_first) begin
        first_setup_word <= wdata16;
      end
      if (wr_second) begin
        second_setup_word <= wdata16;
      end
      if (wr_pulse) begin
        encoder_pulse_count_param <= wdata16;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_enable <= '0;
    end else if (wr_enable) begin
      irq_enable <= reg_wdata[`IRQ_W-1:0];
    end
  end

  // active copies change only on a power restart
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      active_first  <= `FIRST_SETUP_RESET;
      active_second <= `SECOND_SETUP_RESET; // see R15
    end else if (apply_now) begin
      active_first  <= first_setup_word;    // see R8
      active_second <= second_setup_word;   // see R8
    end
  end

  // ---------------- events ----------------
  wire ev_pending  = (wr_first & (wdata16 != active_first)) |
                     (wr_second & (wdata16 != active_second));
  // reserved bits are stored as written, but flagged so a misconfiguration is seen
  wire ev_reserved = wr_second & ((wdata16 & `B2_MUST_ZERO) != 16'h0000); // see R7
  wire staged_abs  = first_setup_word[`B1_ENCODER];
  wire ev_count    = apply_now & staged_abs &
                     (encoder_pulse_count_param != `ABS_PULSE_COUNT); // see R13

  logic [`IRQ_W-1:0] irq_set;
  logic [`IRQ_W-1:0] irq_clr;
  logic [`IRQ_W-1:0] next_irq_status;

  always_comb begin
    irq_set                   = '0;
    irq_set[`IRQ_APPLIED]     = apply_now;
    irq_set[`IRQ_PENDING]     = ev_pending;
    irq_set[`IRQ_RESERVED]    = ev_reserved;
    irq_set[`IRQ_PULSE_COUNT] = ev_count;
    irq_clr                   = wr_clear ? reg_wdata[`IRQ_W-1:0] : '0;
    // a set in the clearing cycle survives
    next_irq_status           = (irq_status & ~irq_clr) | irq_set;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_status <= '0;
      irq        <= 1'b0;
    end else begin
      irq_status <= next_irq_status;
      irq        <= |(next_irq_status & irq_enable);
    end
  end

  // ---------------- mode decode ----------------
  wire       cmd_source  = active_second[`B2_CMD_SOURCE];
  wire [1:0] mode_sel    = {active_first[`B1_MODE_HI], active_first[`B1_MODE_LO]};
  wire       is_absolute = active_first[`B1_ENCODER]; // see R12

  control_mode_e next_control_mode;

  always_comb begin
    next_control_mode = mode_speed;
    if (!cmd_source) begin
      case (mode_sel) // see R9
        2'b00:   next_control_mode = mode_speed;
        2'b01:   next_control_mode = mode_speed_position_lock;
        2'b10:   next_control_mode = mode_torque;
        2'b11:   next_control_mode = mode_torque_speed_switch;
        default: next_control_mode = mode_speed;
      endcase
    end else if (reduced_strap) begin
      next_control_mode = mode_preset_servo_lock; // see R11
    end else begin
      case (mode_sel) // see R10
        2'b00:   next_control_mode = mode_preset_servo_lock;
        2'b01:   next_control_mode = mode_preset_position_lock;
        2'b10:   next_control_mode = mode_preset_speed_servo_lock;
        2'b11:   next_control_mode = mode_preset_speed_position_lock;
        default: next_control_mode = mode_preset_servo_lock;
      endcase
    end
  end

  // speed control covers every mode that closes the loop on a speed command
  wire speed_ctrl = (next_control_mode == mode_speed) ||
                    (next_control_mode == mode_speed_position_lock) ||
                    (next_control_mode == mode_preset_speed_servo_lock) ||
                    (next_control_mode == mode_preset_speed_position_lock);

  wire next_analog_limit = active_second[`B2_ANALOG_LIMIT] & speed_ctrl; // see R6
  wire polarity_cw       = active_second[`B2_POLARITY];

  // negation saturates so the most negative command does not wrap
  wire signed [15:0] negated_speed = (speed_command == 16'sh8000) ? 16'sh7fff
                                                                   : -speed_command;
  wire signed [15:0] next_speed    = polarity_cw ? negated_speed : speed_command; // see R1

  wire [9:0] next_integ_step = active_second[`B2_INTEG_UNITS] ? `INTEG_STEP_FINE
                                                              : `INTEG_STEP_COARSE; // see R4
  wire [11:0] next_limit     = next_analog_limit ? torque_command_in : `CURRENT_LIMIT_FULL;

  // ---------------- decoded outputs ----------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      control_mode <= mode_speed;
      stop_method  <= '0;
    end else begin
      control_mode <= next_control_mode;
      stop_method  <= active_first[`B1_STOP_HI:`B1_STOP_LO]; // see R14
    end
  end

  // polarity and the speed it steers leave on one edge, so they never disagree
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rotate_cw_positive  <= 1'b0;
      motor_speed_command <= '0;
    end else begin
      rotate_cw_positive  <= polarity_cw; // see R1
      motor_speed_command <= next_speed;  // see R1
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      origin_error_detect_en  <= 1'b0;
      absolute_encoder_option <= 1'b0;
    end else begin
      origin_error_detect_en  <= is_absolute & ~active_second[`B2_ORIGIN_MASK]; // see R2
      absolute_encoder_option <= is_absolute; // see R12
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      integ_step_us              <= `INTEG_STEP_COARSE;
      torque_filter_second_order <= 1'b0;
    end else begin
      integ_step_us              <= next_integ_step;                 // see R4
      torque_filter_second_order <= active_second[`B2_FILTER_ORDER]; // see R5
    end
  end

  // the limit level follows the torque input every cycle while enabled
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      analog_current_limit_en <= 1'b0;
      current_limit_level     <= `CURRENT_LIMIT_FULL;
    end else begin
      analog_current_limit_en <= next_analog_limit; // see R6
      current_limit_level     <= next_limit;        // see R6
    end
  end

  // multipurpose pins routed to one function set or the other
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      forward_current_limit_in <= 1'b0;
      reverse_current_limit_in <= 1'b0;
      speed_select_one         <= 1'b0;
      speed_select_two         <= 1'b0;
      rotation_direction_in    <= 1'b0;
    end else begin
      forward_current_limit_in <= ~cmd_source & mp_one;   // see R3
      reverse_current_limit_in <= ~cmd_source & mp_two;   // see R3
      speed_select_one         <= cmd_source & mp_one;    // see R3
      speed_select_two         <= cmd_source & mp_two;    // see R3
      rotation_direction_in    <= cmd_source & mp_three;  // see R3
    end
  end

  // ---------------- read path ----------------
  wire [31:0] mode_status = {24'h0000_00, is_absolute, reduced_strap, cmd_source,
                             2'b00, next_control_mode};

  logic [31:0] read_mux;

  always_comb begin
    case (reg_addr)
      `OFF_FIRST_SETUP:   read_mux = {16'h0000, first_setup_word};
      `OFF_SECOND_SETUP:  read_mux = {16'h0000, second_setup_word};
      `OFF_PULSE_COUNT:   read_mux = {16'h0000, encoder_pulse_count_param};
      `OFF_ACTIVE_FIRST:  read_mux = {16'h0000, active_first};
      `OFF_ACTIVE_SECOND: read_mux = {16'h0000, active_second};
      `OFF_MODE_STATUS:   read_mux = mode_status;
      `OFF_IRQ_STATUS:    read_mux = {28'h000_0000, irq_status};
      `OFF_IRQ_ENABLE:    read_mux = {28'h000_0000, irq_enable};
      default:            read_mux = 32'h0000_0000;
    endcase
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= reg_rd ? read_mux : 32'h0000_0000;
    end
  end

endmodule : servo_setup_mode_decoder

// >>> rtl/sync_two_stage.sv
// two flip-flop synchroniser for pin levels
`timescale 1ns/1ns
module sync_two_stage #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta;

  // meta feeds only the second stage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta     <= '0;
      sync_out <= '0;
    end else begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end

endmodule : sync_two_stage

// >>> tb/host_ctrl_model.sv
// host controller stand-in that drives the command pins just after each clock edge
`timescale 1ns/1ns
module host_ctrl_model (
  input  wire logic          clk,
  input  wire logic [2:0]    mp_req,
  input  wire logic          restart_req,
  output logic               multipurpose_in_one,
  output logic               multipurpose_in_two,
  output logic               multipurpose_in_three,
  output logic               power_restart,
  output logic signed [15:0] speed_command,
  output logic [11:0]        torque_command_in
);
  logic [3:0] wob = 4'h0;
  // one process owns every pin; torque wanders so a stale sample of it cannot pass
  initial begin
    {multipurpose_in_three, multipurpose_in_two, multipurpose_in_one} = 3'h0;
    power_restart = 1'b0;
    speed_command = 16'sd1234;
    torque_command_in = 12'h5a0;
    forever begin
      @(posedge clk);
      wob <= wob + 4'h1;
      {multipurpose_in_three, multipurpose_in_two, multipurpose_in_one} <= mp_req;
      power_restart <= restart_req;
      torque_command_in <= {8'h5a, wob};
    end
  end
endmodule : host_ctrl_model

// >>> tb/servo_setup_mode_decoder_assertions.sv
// port-level checks of the setup decoder
`timescale 1ns/1ns
module servo_setup_checker
  import servo_setup_pkg::*;
(
  input wire logic               clk,
  input wire logic               rst_n,
  input wire logic               reg_rd,
  input wire logic [31:0]        reg_rdata,
  input wire logic               power_restart,
  input wire logic               reduced_variant,
  input wire logic               multipurpose_in_one,
  input wire logic signed [15:0] speed_command,
  input wire logic [11:0]        torque_command_in,
  input wire logic signed [15:0] motor_speed_command,
  input wire logic               rotate_cw_positive,
  input wire logic               origin_error_detect_en,
  input wire logic               forward_current_limit_in,
  input wire logic               speed_select_one,
  input wire logic               analog_current_limit_en,
  input wire logic [11:0]        current_limit_level,
  input wire control_mode_e      control_mode,
  input wire logic               absolute_encoder_option
);
  logic [3:0] since_restart;
  logic       restarted;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      since_restart <= 4'hf;
      restarted <= 1'b0;
    end else begin
      since_restart <= power_restart ? 4'h0 : since_restart + {3'h0, since_restart != 4'hf};
      restarted <= restarted | power_restart;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_ccw; $past(rst_n) && !rotate_cw_positive
    |-> motor_speed_command == $past(speed_command); endproperty
  a_ccw: assert property (p_ccw) else $error("ccw speed");
  property p_cw; $past(rst_n) && rotate_cw_positive && $past(speed_command) != 16'sh8000
    |-> motor_speed_command == -$past(speed_command); endproperty
  a_cw: assert property (p_cw) else $error("cw speed");
  property p_origin; origin_error_detect_en |-> absolute_encoder_option; endproperty
  a_origin: assert property (p_origin) else $error("origin detect");
  property p_route; forward_current_limit_in
    |-> !speed_select_one && $past(multipurpose_in_one, 3); endproperty
  a_route: assert property (p_route) else $error("pin routing");
  property p_lim_mode; analog_current_limit_en |-> control_mode inside {mode_speed,
    mode_speed_position_lock, mode_preset_speed_servo_lock, mode_preset_speed_position_lock};
  endproperty
  a_lim_mode: assert property (p_lim_mode) else $error("limit outside speed");
  property p_lim; $past(rst_n) && analog_current_limit_en
    |-> current_limit_level == $past(torque_command_in); endproperty
  a_lim: assert property (p_lim) else $error("limit level");
  property p_full; !analog_current_limit_en |-> current_limit_level == 12'hfff; endproperty
  a_full: assert property (p_full) else $error("limit not full");
  property p_held; $changed(control_mode) || $changed(rotate_cw_positive)
    |-> since_restart < 4'h8; endproperty
  a_held: assert property (p_held) else $error("change without restart");
  property p_reduced; reduced_variant && control_mode[2]
    |-> control_mode == mode_preset_servo_lock; endproperty
  a_reduced: assert property (p_reduced) else $error("reduced mode");
  property p_factory; !restarted
    |-> control_mode == mode_speed && !rotate_cw_positive; endproperty
  a_factory: assert property (p_factory) else $error("factory state");
  property p_rdata; $past(rst_n) && !$past(reg_rd) |-> reg_rdata == 32'h0; endproperty
  a_rdata: assert property (p_rdata) else $error("read data idle");
endmodule : servo_setup_checker

bind servo_setup_mode_decoder servo_setup_checker chk_u (.clk, .rst_n, .reg_rd, .reg_rdata,
  .power_restart, .reduced_variant, .multipurpose_in_one, .speed_command, .torque_command_in,
  .motor_speed_command, .rotate_cw_positive, .origin_error_detect_en,
  .forward_current_limit_in, .speed_select_one, .analog_current_limit_en,
  .current_limit_level, .control_mode, .absolute_encoder_option);

// >>> tb/test_servo_setup_mode_decoder.sv
// self-checking bench: register calls, power restarts and expected settings
`timescale 1ns/1ns
`include "servo_setup_consts.svh"
`define CHK(n, e, g) check(n, 32'(e), 32'(g))
module test_servo_setup_mode_decoder
  import servo_setup_pkg::*;
;
  logic               clk = 1'b0;
  logic               rst_n = 1'b0;
  logic [7:0]         reg_addr = 8'h00;
  logic [31:0]        reg_wdata = 32'h0000_0000;
  logic               reg_wr = 1'b0;
  logic               reg_rd = 1'b0;
  logic               reduced_variant = 1'b0;
  logic [2:0]         mp_req = 3'h0;
  logic               restart_req = 1'b0;
  logic [31:0]        reg_rdata, rd_val;
  logic               irq, power_restart, rotate_cw_positive, origin_error_detect_en;
  logic               multipurpose_in_one, multipurpose_in_two, multipurpose_in_three;
  logic               forward_current_limit_in, reverse_current_limit_in, speed_select_one;
  logic               speed_select_two, rotation_direction_in, torque_filter_second_order;
  logic               analog_current_limit_en, absolute_encoder_option;
  logic signed [15:0] speed_command, motor_speed_command, exp_spd;
  logic [11:0]        torque_command_in, current_limit_level;
  logic [9:0]         integ_step_us;
  logic [3:0]         stop_method;
  logic [15:0]        w1, w2;
  logic [2:0]         mb;
  logic [4:0]         exp_pins, routed;
  control_mode_e      control_mode, prev_mode;
  int                 miscompares = 0;
  int                 n_compared = 0;

  assign routed = {rotation_direction_in, speed_select_two, speed_select_one,
                   reverse_current_limit_in, forward_current_limit_in};
  always #2 clk = ~clk;

  host_ctrl_model host_u (.clk, .mp_req, .restart_req, .multipurpose_in_one,
    .multipurpose_in_two, .multipurpose_in_three, .power_restart, .speed_command,
    .torque_command_in);
  servo_setup_mode_decoder dut_u (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .irq, .power_restart, .reduced_variant, .multipurpose_in_one,
    .multipurpose_in_two, .multipurpose_in_three, .speed_command, .torque_command_in,
    .motor_speed_command, .rotate_cw_positive, .origin_error_detect_en,
    .forward_current_limit_in, .reverse_current_limit_in, .speed_select_one,
    .speed_select_two, .rotation_direction_in, .integ_step_us, .torque_filter_second_order,
    .analog_current_limit_en, .current_limit_level, .control_mode,
    .absolute_encoder_option, .stop_method);

  task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 rd_val = reg_rdata;
  endtask : rd
  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask : settle
  // the pin stays high well past the synchroniser and goes low before the next restart
  task automatic restart();
    @(posedge clk);
    restart_req <= 1'b1;
    repeat (8) @(posedge clk);
    restart_req <= 1'b0;
    repeat (8) @(posedge clk);
    #1;
  endtask : restart
  task automatic do_reset(input logic strap);
    @(posedge clk);
    rst_n <= 1'b0;
    reduced_variant <= strap;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
  endtask : do_reset
  task automatic stop_test();
    $display("compared %0d, miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : stop_test

  initial begin
    #100000;
    miscompares++;
    stop_test();
  end

  initial begin
    do_reset(1'b0);
    rd(`OFF_SECOND_SETUP);
    `CHK("second_setup_word", `SECOND_SETUP_RESET, rd_val);
    rd(8'h3c);
    `CHK("unmapped read", 0, rd_val);
    wr(`OFF_ACTIVE_FIRST, 32'h0000_ffff);
    wr(`OFF_SECOND_SETUP, 32'h0000_0009);
    rd(`OFF_ACTIVE_FIRST);
    `CHK("read-only write", 0, rd_val);
    `CHK("polarity before restart", 0, rotate_cw_positive);
    rd(`OFF_IRQ_STATUS);
    `CHK("irq status", 32'h0000_0006, rd_val);
    `CHK("irq masked", 0, irq);
    wr(`OFF_IRQ_ENABLE, 32'h0000_0004);
    settle();
    `CHK("irq enabled", 1, irq);
    wr(`OFF_IRQ_CLEAR, 32'h0000_0006);
    settle();
    `CHK("irq cleared", 0, irq);
    prev_mode = mode_speed;
    for (int m = 0; m < 8; m++) begin
      mb = 3'(m);
      w1 = {1'b0, mb[0], 2'b00, mb[1:0], mb[0], ~mb, 6'h00};
      w2 = {~mb[0], 2'b00, mb[1], mb[1] ^ mb[0], 8'h00, mb[2], m == 5, mb[0]};
      exp_spd = mb[0] ? -16'sd1234 : 16'sd1234;
      mp_req <= mb ^ 3'h3;
      wr(`OFF_PULSE_COUNT, {16'h0000, `ABS_PULSE_COUNT});
      wr(`OFF_FIRST_SETUP, {16'h0000, w1});
      wr(`OFF_SECOND_SETUP, {16'h0000, w2});
      settle();
      `CHK("mode before restart", prev_mode, control_mode);
      restart();
      prev_mode = control_mode_e'(mb);
      exp_pins = mb[2] ? {mp_req, 2'b00} : {3'b000, mp_req[1:0]};
      `CHK("control_mode", mb, control_mode);
      `CHK("polarity", {mb[0], exp_spd}, {rotate_cw_positive, motor_speed_command});
      `CHK("pin routing", exp_pins, routed);
      `CHK("integ", mb[1] ^ mb[0] ? `INTEG_STEP_FINE : `INTEG_STEP_COARSE, integ_step_us);
      `CHK("filter order", mb[1], torque_filter_second_order);
      `CHK("analog limit", !mb[0] && mb[1] == mb[2], analog_current_limit_en);
      if (mb[0] || mb[1] != mb[2])
        `CHK("current limit", `CURRENT_LIMIT_FULL, current_limit_level);
      `CHK("encoder", {mb[0], mb[0] && m != 5},
           {absolute_encoder_option, origin_error_detect_en});
      `CHK("stop method", {mb[0], ~mb}, stop_method);
      rd(`OFF_ACTIVE_SECOND);
      `CHK("active second word", w2, rd_val);
    end
    rd(`OFF_IRQ_STATUS);
    `CHK("restart applied flag", 1, rd_val[0]);
    do_reset(1'b1);
    wr(`OFF_FIRST_SETUP, 32'h0000_4c00);
    wr(`OFF_SECOND_SETUP, 32'h0000_0004);
    wr(`OFF_IRQ_ENABLE, 32'h0000_0008);
    restart();
    `CHK("reduced mode", mode_preset_servo_lock, control_mode);
    `CHK("pulse count irq", 1, irq);
    wr(`OFF_IRQ_CLEAR, 32'h0000_000f);
    settle();
    `CHK("irq after clear", 0, irq);
    stop_test();
  end
endmodule : test_servo_setup_mode_decoder
